//--- core/mbsp_defs.vh
// register offsets, field positions and reset values for the serial port
`ifndef MBSP_DEFS_VH
`define MBSP_DEFS_VH
// ======================================================
// register offsets (word index on the peripheral bus)
`define MBSP_A_RX_UPPER 5'h00
`define MBSP_A_RX_LOWER 5'h01
`define MBSP_A_TX_UPPER 5'h02
`define MBSP_A_TX_LOWER 5'h03
`define MBSP_A_PORT_CTL_B 5'h04
`define MBSP_A_PORT_CTL_A 5'h05
`define MBSP_A_RX_CTL_B 5'h06
`define MBSP_A_RX_CTL_A 5'h07
`define MBSP_A_TX_CTL_B 5'h08
`define MBSP_A_TX_CTL_A 5'h09
`define MBSP_A_RATE_B 5'h0a
`define MBSP_A_RATE_A 5'h0b
`define MBSP_A_MCH_CTL_B 5'h0c
`define MBSP_A_MCH_CTL_A 5'h0d
`define MBSP_A_RX_CHEN_A 5'h0e
`define MBSP_A_RX_CHEN_B 5'h0f
`define MBSP_A_TX_CHEN_A 5'h10
`define MBSP_A_TX_CHEN_B 5'h11
`define MBSP_A_PIN_CTL 5'h12
`define MBSP_A_RX_CHEN_C 5'h13
`define MBSP_A_RX_CHEN_D 5'h14
`define MBSP_A_TX_CHEN_C 5'h15
`define MBSP_A_TX_CHEN_D 5'h16
`define MBSP_NREGS 23
`define MBSP_RESET_VAL 16'h0000
// ======================================================
// field positions
// port_control_a: bit 0 receiver enable, bit 1 fifo mode
`define MBSP_B_RX_EN 0
`define MBSP_B_FIFO_MODE 1
// port_control_b: bit 0 transmitter enable, bit 1 rx ready, bit 2 tx ready
`define MBSP_B_TX_EN 0
`define MBSP_B_RX_RDY 1
`define MBSP_B_TX_RDY 2
// rx/tx control_a: word length code [7:5], lsb-first bit 4
`define MBSP_F_WLEN_HI 7
`define MBSP_F_WLEN_LO 5
`define MBSP_B_LSB_FIRST 4
// pin_control bits
`define MBSP_B_RX_CLK_POL 0
`define MBSP_B_TX_CLK_POL 1
`define MBSP_B_RX_FS_POL 2
`define MBSP_B_TX_FS_POL 3
`define MBSP_B_RX_CLK_INT 8
`define MBSP_B_TX_CLK_INT 9
// rate_generator_b: source select [13:12]
`define MBSP_F_SRC_HI 13
`define MBSP_F_SRC_LO 12
`define MBSP_SRC_PERIPH 2'h0
`define MBSP_SRC_TXCLK 2'h1
`define MBSP_SRC_RXCLK 2'h2
// multichannel_control_a bit 0 rx multichannel, _b bit 0 tx multichannel
`define MBSP_B_MCH_EN 0
`endif

//--- core/mbsp_fifo.v
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module mbsp_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire i_clr,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_r;
	reg [AW-1:0] rd_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;
	assign o_in_ready = (cnt_r != DEPTH[AW:0]);
	assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
	assign o_out_data = mem[rd_r];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	always @(posedge i_ref_clk)
	begin
		if (!i_nrst || i_clr)
		begin
			wr_r <= {AW{1'b0}};
			rd_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem[wr_r] <= i_in_data;
				wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					wr_r + 1'b1;
			end
			if (pop)
				rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					rd_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule // mbsp_fifo

//--- core/mbsp_port.v
// buffered serial port core: registers, rate generator, rx and tx shifters
// ======================================================
// Notes on behaviour
// - receiver and transmitter run at the same time, independently.
// - each direction has a buffer stage ahead of its shift register.
// - receive and transmit have separate frame sync and shift clock.
// - each shift clock is external or internally generated, per bit.
// - word lengths 8, 12, 16, 20, 24, 32 selectable per direction.
// - 8-bit words shift lsb first or msb first as configured.
// - frame sync and clock polarity are programmable.
// - generated clock is source clock over one plus divider; source selectable.
// - transmit path has sixteen-word buffering (two 16-bit halves).
// - receive path has sixteen-word buffering (two 16-bit halves).
// - in fifo mode data addresses map to fifo tops.
// - fifo pointers advance by order of upper/lower access.
// - upper access alone never moves pointers; lower access does.
// - separate rx and tx channel enable partitions pick active slots.
// - every register reads zero after reset except port_control_b, whose tx ready bit reads one.
`timescale 1ns/1ps
`include "mbsp_defs.vh"
module mbsp_port #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire [4:0] i_addr,
	input wire i_rd,
	input wire i_wr,
	input wire [15:0] i_wdata,
	output reg [15:0] o_rdata,
	input wire i_ext_rx_clk,
	input wire i_ext_tx_clk,
	input wire i_rx_fs,
	input wire i_tx_fs,
	input wire i_rx_data,
	output reg o_tx_data,
	output reg o_tx_data_oe,
	output reg o_port_clk
);
	// ======================================================
	// register file
	reg [15:0] regs_r [0:`MBSP_NREGS-1];
	reg [15:0] tx_upper_r;
	reg [31:0] rx_buf_r;
	reg rx_full_r;
	reg [15:0] rx_upper_r;
	reg [31:0] tx_buf_r;
	reg tx_full_r;
	integer k;
	wire [15:0] pca = regs_r[`MBSP_A_PORT_CTL_A];
	wire [15:0] pcb = regs_r[`MBSP_A_PORT_CTL_B];
	wire [15:0] pin = regs_r[`MBSP_A_PIN_CTL];
	wire [15:0] rga = regs_r[`MBSP_A_RATE_A];
	wire [15:0] rgb = regs_r[`MBSP_A_RATE_B];
	wire fifo_mode = pca[`MBSP_B_FIFO_MODE];
	wire rx_en = pca[`MBSP_B_RX_EN];
	wire tx_en = pcb[`MBSP_B_TX_EN];
	wire [2:0] rx_wcode =
		regs_r[`MBSP_A_RX_CTL_A][`MBSP_F_WLEN_HI:`MBSP_F_WLEN_LO];
	wire [2:0] tx_wcode =
		regs_r[`MBSP_A_TX_CTL_A][`MBSP_F_WLEN_HI:`MBSP_F_WLEN_LO];

	// word length code to bit count: 8,12,16,20,24,32
	function [5:0] wlen;
		input [2:0] code;
		begin
			case (code)
				3'h0: wlen = 6'd8;
				3'h1: wlen = 6'd12;
				3'h2: wlen = 6'd16;
				3'h3: wlen = 6'd20;
				3'h4: wlen = 6'd24;
				default: wlen = 6'd32;
			endcase
		end
	endfunction

	// reverse the low byte for lsb-first 8-bit words
	function [31:0] bitrev8;
		input [31:0] w;
		integer j;
		begin
			bitrev8 = w;
			for (j = 0; j < 8; j = j + 1)
				bitrev8[j] = w[7-j];
		end
	endfunction

	wire [5:0] rx_bits = wlen(rx_wcode);
	wire [5:0] tx_bits = wlen(tx_wcode);

	// ======================================================
	// rate generator
	reg [7:0] div_cnt_r;
	reg src_d_r;
	reg src_edge;
	reg generated_port_clock_tick;
	always @*
	begin
		case (rgb[`MBSP_F_SRC_HI:`MBSP_F_SRC_LO])
			`MBSP_SRC_TXCLK: src_edge = i_ext_tx_clk & ~src_d_r;
			`MBSP_SRC_RXCLK: src_edge = i_ext_rx_clk & ~src_d_r;
			default: src_edge = 1'b1;
		endcase
		generated_port_clock_tick = src_edge && (div_cnt_r == rga[7:0]);
	end
	wire src_lvl = (rgb[`MBSP_F_SRC_HI:`MBSP_F_SRC_LO] == `MBSP_SRC_TXCLK) ?
		i_ext_tx_clk : i_ext_rx_clk;

	// external clock edges, with programmable polarity
	reg rx_clk_d_r;
	reg tx_clk_d_r;
	wire rx_clk_pol = i_ext_rx_clk ^ pin[`MBSP_B_RX_CLK_POL];
	wire tx_clk_pol = i_ext_tx_clk ^ pin[`MBSP_B_TX_CLK_POL];
	wire rx_tick = pin[`MBSP_B_RX_CLK_INT] ? generated_port_clock_tick :
		(rx_clk_pol & ~rx_clk_d_r);
	wire tx_tick = pin[`MBSP_B_TX_CLK_INT] ? generated_port_clock_tick :
		(tx_clk_pol & ~tx_clk_d_r);
	wire rx_fs = i_rx_fs ^ pin[`MBSP_B_RX_FS_POL];
	wire tx_fs = i_tx_fs ^ pin[`MBSP_B_TX_FS_POL];

	always @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			div_cnt_r <= 8'h00;
			src_d_r <= 1'b0;
			rx_clk_d_r <= 1'b0;
			tx_clk_d_r <= 1'b0;
			o_port_clk <= 1'b0;
		end
		else
		begin
			src_d_r <= src_lvl;
			rx_clk_d_r <= rx_clk_pol;
			tx_clk_d_r <= tx_clk_pol;
			if (generated_port_clock_tick)
			begin
				div_cnt_r <= 8'h00;
				o_port_clk <= ~o_port_clk;
			end
			else if (src_edge)
				div_cnt_r <= div_cnt_r + 8'h01;
		end
	end

	// ======================================================
	// fifos: 32-bit words, i.e. a pair of 16-bit halves
	wire rxf_in_ready;
	wire rxf_valid;
	wire [31:0] rxf_data;
	wire txf_in_ready;
	wire txf_valid;
	wire [31:0] txf_data;
	wire wr_tx_lo = i_wr && i_addr == `MBSP_A_TX_LOWER;
	wire rd_rx_lo = i_rd && i_addr == `MBSP_A_RX_LOWER;
	wire txf_pop = fifo_mode && !tx_full_r && txf_valid;
	wire rxf_push = fifo_mode && rx_full_r;

	mbsp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txf (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_clr(!fifo_mode),
		.i_in_valid(fifo_mode && wr_tx_lo),
		.o_in_ready(txf_in_ready),
		.i_in_data({tx_upper_r, i_wdata}),
		.o_out_valid(txf_valid),
		.i_out_ready(txf_pop),
		.o_out_data(txf_data)
	);
	mbsp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rxf (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_clr(!fifo_mode),
		.i_in_valid(rxf_push),
		.o_in_ready(rxf_in_ready),
		.i_in_data(rx_buf_r),
		.o_out_valid(rxf_valid),
		.i_out_ready(fifo_mode && rd_rx_lo),
		.o_out_data(rxf_data)
	);

	// ======================================================
	// receiver
	reg [31:0] rx_sh_r;
	reg [5:0] rx_cnt_r;
	reg rx_act_r;
	reg [5:0] rx_slot_r;
	wire [63:0] rx_chen = {regs_r[`MBSP_A_RX_CHEN_D],
		regs_r[`MBSP_A_RX_CHEN_C], regs_r[`MBSP_A_RX_CHEN_B],
		regs_r[`MBSP_A_RX_CHEN_A]};
	wire rx_mch = regs_r[`MBSP_A_MCH_CTL_A][`MBSP_B_MCH_EN];
	wire rx_slot_on = !rx_mch || rx_chen[rx_slot_r];
	wire [31:0] rx_sh_nxt = {rx_sh_r[30:0], i_rx_data};
	wire rx_lsbf = regs_r[`MBSP_A_RX_CTL_A][`MBSP_B_LSB_FIRST] &&
		rx_bits == 6'd8;
	// the word lands on the tick of its last bit, so no extra edge is needed
	wire rx_done = rx_en && rx_act_r && rx_tick && !rx_fs &&
		rx_cnt_r == rx_bits - 6'h01;
	// buffer drained by fifo or by software read of the lower half
	wire rx_drain = fifo_mode ? rxf_in_ready : rd_rx_lo;

	always @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			rx_sh_r <= 32'h0000_0000;
			rx_cnt_r <= 6'h00;
			rx_act_r <= 1'b0;
			rx_slot_r <= 6'h00;
			rx_buf_r <= 32'h0000_0000;
			rx_full_r <= 1'b0;
		end
		else
		begin
			if (rx_full_r && rx_drain)
				rx_full_r <= 1'b0;
			if (rx_en && rx_tick)
			begin
				if (rx_fs)
				begin
					rx_act_r <= 1'b1;
					rx_cnt_r <= 6'h01;
					rx_slot_r <= 6'h00;
					rx_sh_r <= {31'h0000_0000, i_rx_data};
				end
				else if (rx_act_r)
				begin
					rx_sh_r <= rx_sh_nxt;
					rx_cnt_r <= (rx_cnt_r == rx_bits) ? 6'h01 :
						rx_cnt_r + 6'h01;
				end
			end
			// a completed word in an enabled slot lands in the buffer stage; set wins the clear
			if (rx_done && rx_slot_on)
			begin
				rx_buf_r <= rx_lsbf ? bitrev8(rx_sh_nxt) : rx_sh_nxt;
				rx_full_r <= 1'b1;
			end
			if (rx_done)
				rx_slot_r <= rx_slot_r + 6'h01;
		end
	end

	// ======================================================
	// transmitter
	reg [31:0] tx_sh_r;
	reg [5:0] tx_cnt_r;
	reg [5:0] tx_slot_r;
	wire [63:0] tx_chen = {regs_r[`MBSP_A_TX_CHEN_D],
		regs_r[`MBSP_A_TX_CHEN_C], regs_r[`MBSP_A_TX_CHEN_B],
		regs_r[`MBSP_A_TX_CHEN_A]};
	wire tx_mch = regs_r[`MBSP_A_MCH_CTL_B][`MBSP_B_MCH_EN];
	wire tx_lsbf = regs_r[`MBSP_A_TX_CTL_A][`MBSP_B_LSB_FIRST] &&
		tx_bits == 6'd8;
	wire [31:0] tx_word = tx_lsbf ? bitrev8(tx_buf_r) : tx_buf_r;
	wire [31:0] tx_aligned = tx_word << (6'd32 - tx_bits);
	wire tx_last = tx_cnt_r == 6'h01;
	wire tx_load = tx_en && tx_tick && (tx_fs || (tx_last && tx_slot_r != 0));
	wire tx_next_on = !tx_mch || tx_chen[tx_fs ? 6'h00 : tx_slot_r];

	always @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			tx_sh_r <= 32'h0000_0000;
			tx_cnt_r <= 6'h00;
			tx_slot_r <= 6'h00;
			tx_buf_r <= 32'h0000_0000;
			tx_full_r <= 1'b0;
			tx_upper_r <= 16'h0000;
			o_tx_data <= 1'b0;
			o_tx_data_oe <= 1'b0;
		end
		else
		begin
			if (i_wr && i_addr == `MBSP_A_TX_UPPER)
				tx_upper_r <= i_wdata;
			if (!fifo_mode && wr_tx_lo)
			begin
				tx_buf_r <= {tx_upper_r, i_wdata};
				tx_full_r <= 1'b1;
			end
			else if (txf_pop)
			begin
				tx_buf_r <= txf_data;
				tx_full_r <= 1'b1;
			end
			if (tx_en && tx_tick)
			begin
				if (tx_load)
				begin
					// empty slot or disabled channel: line released
					o_tx_data_oe <= tx_next_on && tx_full_r;
					o_tx_data <= tx_aligned[31];
					tx_sh_r <= {tx_aligned[30:0], 1'b0};
					tx_cnt_r <= tx_bits;
					tx_slot_r <= tx_fs ? 6'h01 : tx_slot_r + 6'h01;
					if (tx_next_on && !(!fifo_mode && wr_tx_lo))
						tx_full_r <= 1'b0;
				end
				else if (tx_cnt_r > 6'h01)
				begin
					o_tx_data <= tx_sh_r[31];
					tx_sh_r <= {tx_sh_r[30:0], 1'b0};
					tx_cnt_r <= tx_cnt_r - 6'h01;
				end
				else
					o_tx_data_oe <= 1'b0;
			end
		end
	end

	// ======================================================
	// register bus: reads of data registers and control writes
	wire [31:0] rx_src = fifo_mode ? rxf_data : rx_buf_r;
	always @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			for (k = 0; k < `MBSP_NREGS; k = k + 1)
				regs_r[k] <= `MBSP_RESET_VAL;
			rx_upper_r <= 16'h0000;
			o_rdata <= 16'h0000;
		end
		else
		begin
			if (i_wr && i_addr >= `MBSP_A_PORT_CTL_B &&
				i_addr <= `MBSP_A_TX_CHEN_D)
				regs_r[i_addr] <= i_wdata;
			// status bits are reflected into port_control_b
			regs_r[`MBSP_A_PORT_CTL_B][`MBSP_B_RX_RDY] <=
				fifo_mode ? rxf_valid : rx_full_r;
			regs_r[`MBSP_A_PORT_CTL_B][`MBSP_B_TX_RDY] <=
				fifo_mode ? txf_in_ready : !tx_full_r;
			// upper read latches the upper half in rx_upper_r; the lower read takes rx_src directly
			if (i_rd && i_addr == `MBSP_A_RX_UPPER)
				rx_upper_r <= rx_src[31:16];
			if (i_rd)
			begin
				case (i_addr)
					`MBSP_A_RX_UPPER: o_rdata <= rx_src[31:16];
					`MBSP_A_RX_LOWER: o_rdata <= rx_src[15:0];
					`MBSP_A_TX_UPPER: o_rdata <= 16'h0000;
					`MBSP_A_TX_LOWER: o_rdata <= 16'h0000;
					default: o_rdata <= (i_addr < `MBSP_NREGS) ?
						regs_r[i_addr] : 16'h0000;
				endcase
			end
		end
	end
endmodule // mbsp_port

//--- verif/mbsp_port_sva.sv
// concurrent checks on the serial port register bus and pins
`timescale 1ns/1ps
module mbsp_port_sva (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire [4:0] i_addr,
	input wire i_rd,
	input wire i_wr,
	input wire [15:0] i_wdata,
	input wire [15:0] o_rdata,
	input wire o_tx_data,
	input wire o_tx_data_oe,
	input wire o_port_clk
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);
	// ==========
	// shadow bits
	// mirrored from bus writes, since the checker cannot see the registers
	reg tx_en_r;
	reg fifo_r;
	always @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			tx_en_r <= 1'b0;
			fifo_r <= 1'b0;
		end
		else
		begin
			if (i_wr && i_addr == 5'h04)
				tx_en_r <= i_wdata[0];
			if (i_wr && i_addr == 5'h05)
				fifo_r <= i_wdata[1];
		end
	end
	// ==========
	// sequences and properties
	sequence s_up_rd;
		fifo_r && i_rd && !i_wr && i_addr == 5'h00;
	endsequence
	property p_readback;
		logic [4:0] a;
		logic [15:0] d;
		(i_wr && i_addr inside {[5'h06:5'h16]}, a = i_addr, d = i_wdata)
			##2 (i_rd && i_addr == a) |=> o_rdata == d;
	endproperty
	// ==========
	// assertions
	a_reset_rdata: assert property (
		disable iff (1'b0) !i_nrst |=> o_rdata == 16'h0000)
		else $error("read data not cleared by reset");
	a_reset_pins: assert property (
		disable iff (1'b0) !i_nrst |=> !o_tx_data_oe && !o_tx_data
		&& !o_port_clk)
		else $error("pins not cleared by reset");
	a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (
		i_rd && i_addr > 5'h16 |=> o_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_tx_reg_zero: assert property (
		i_rd && (i_addr == 5'h02 || i_addr == 5'h03) |=> o_rdata == 16'h0000)
		else $error("transmit data register readable");
	a_ctrl_readback: assert property (p_readback)
		else $error("control register readback mismatch");
	a_upper_hold: assert property (
		s_up_rd ##2 s_up_rd |=> o_rdata == $past(o_rdata, 2))
		else $error("upper read moved the fifo");
	a_tx_idle_oe: assert property (
		!tx_en_r && !$past(tx_en_r) |-> !o_tx_data_oe)
		else $error("serial output driven while disabled");
endmodule // mbsp_port_sva
bind mbsp_port mbsp_port_sva chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
	.i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
	.o_rdata(o_rdata), .o_tx_data(o_tx_data), .o_tx_data_oe(o_tx_data_oe),
	.o_port_clk(o_port_clk));

//--- verif/mbsp_codec.sv
// far-side codec model: drives frames into the port, captures its output
`timescale 1ns/1ps
module mbsp_codec (
	input wire i_inv,
	input wire i_tx_data,
	input wire i_tx_oe,
	output wire o_sclk,
	output wire o_fs,
	output logic o_dout
);
	logic [31:0] cap;
	logic sclk_lvl;
	logic fs_lvl;
	// clock stands still between frames
	assign o_sclk = sclk_lvl ^ i_inv;
	assign o_fs = fs_lvl ^ i_inv;
	initial
	begin
		sclk_lvl = 1'b0;
		fs_lvl = 1'b0;
		o_dout = 1'b0;
		cap = 32'h0000_0000;
	end
	task automatic xfer(input logic [31:0] w, input int n, input logic lsb);
		int k;
		cap = 32'h0000_0000;
		for (k = 0; k < n; k++)
		begin
			o_dout = lsb ? w[k] : w[n-1-k];
			fs_lvl = (k == 0);
			#80 sclk_lvl = 1'b1;
			#80 sclk_lvl = 1'b0;
			if (i_tx_oe)
				cap[lsb ? k : n-1-k] = i_tx_data;
		end
		// released line must not keep showing the last bit
		#80 o_dout = ~o_dout;
	endtask
endmodule // mbsp_codec

//--- verif/testbench.sv
// self-checking bench for the buffered serial port
`timescale 1ns/1ps
module testbench;
	logic clk, nrst, rd, wr, inv, txd, oe, pclk, sclk, fs, dout;
	logic [4:0] addr;
	logic [15:0] wdata, rdata, v;
	logic [31:0] fw [2];
	int num_errors, checks, a, c, t1, t3;
	int lens [6] = '{8, 12, 16, 20, 24, 32};
	mbsp_port dut (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_rd(rd),
		.i_wr(wr), .i_wdata(wdata), .o_rdata(rdata), .i_ext_rx_clk(sclk),
		.i_ext_tx_clk(sclk), .i_rx_fs(fs), .i_tx_fs(fs), .i_rx_data(dout),
		.o_tx_data(txd), .o_tx_data_oe(oe), .o_port_clk(pclk));
	mbsp_codec codec (.i_inv(inv), .i_tx_data(txd), .i_tx_oe(oe),
		.o_sclk(sclk), .o_fs(fs), .o_dout(dout));
	// ==========
	// tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [4:0] a_i, input logic [15:0] d);
		@(negedge clk);
		addr = a_i;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task rd_reg(input logic [4:0] a_i, output logic [15:0] d);
		@(negedge clk);
		addr = a_i;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
	endtask
	task rd_chk(input logic [4:0] a_i, input logic [15:0] e);
		rd_reg(a_i, v);
		chk({16'h0000, v}, {16'h0000, e});
	endtask
	task frame(input int cd, input logic [31:0] w, input logic lsb);
		int n, k;
		logic [31:0] m;
		n = lens[cd];
		m = (n == 32) ? 32'hffff_ffff : (32'h0000_0001 << n) - 1;
		wr_reg(5'h07, {8'h00, cd[2:0], lsb, 4'h0});
		wr_reg(5'h09, {8'h00, cd[2:0], lsb, 4'h0});
		if (n > 16)
			wr_reg(5'h02, w[31:16]);
		wr_reg(5'h03, w[15:0]);
		codec.xfer(w, n, lsb);
		v = 16'h0000;
		for (k = 0; k < 20 && v[1] !== 1'b1; k++)
			rd_reg(5'h04, v);
		chk({31'h0, v[1]}, 32'h0000_0001);
		if (n > 16)
			rd_chk(5'h00, w[31:16] & m[31:16]);
		rd_chk(5'h01, w[15:0] & m[15:0]);
		chk(codec.cap, w & m);
	endtask
	task meas(output int t);
		time t0;
		repeat (2) @(posedge pclk);
		t0 = $time;
		@(posedge pclk);
		t = int'($time - t0);
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========
	// clock, watchdog and test sequence
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		num_errors++;
		wrap_up;
	end
	initial
	begin
		{nrst, rd, wr, inv, addr, wdata} = '0;
		fw = '{32'h1234_5678, 32'hfedc_ba98};
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		for (a = 0; a < 23; a++)
			if (a != 4)
				rd_chk(a[4:0], 16'h0000);
		for (a = 6; a < 23; a++)
		begin
			wr_reg(a[4:0], 16'h5a00 | a[15:0]);
			rd_chk(a[4:0], 16'h5a00 | a[15:0]);
			wr_reg(a[4:0], 16'h0000);
		end
		wr_reg(5'h1f, 16'hffff);
		rd_chk(5'h1f, 16'h0000);
		rd_chk(5'h02, 16'h0000);
		wr_reg(5'h0b, 16'h0001);
		meas(t1);
		wr_reg(5'h0b, 16'h0003);
		meas(t3);
		chk(t3, 2 * t1);
		wr_reg(5'h0b, 16'h0000);
		wr_reg(5'h05, 16'h0001);
		wr_reg(5'h04, 16'h0001);
		for (c = 0; c < 6; c++)
		begin
			inv = (c == 1);
			wr_reg(5'h12, inv ? 16'h000f : 16'h0000);
			frame(c, {8{c[3:0]}} ^ 32'ha5c3_96e1, 1'b0);
		end
		frame(0, 32'h0000_00b1, 1'b1);
		wr_reg(5'h05, 16'h0003);
		wr_reg(5'h07, 16'h00a0);
		wr_reg(5'h09, 16'h00a0);
		for (c = 0; c < 2; c++)
		begin
			wr_reg(5'h02, fw[c][31:16]);
			wr_reg(5'h03, fw[c][15:0]);
		end
		for (c = 0; c < 2; c++)
		begin
			codec.xfer(fw[c], 32, 1'b0);
			chk(codec.cap, fw[c]);
		end
		rd_chk(5'h00, fw[0][31:16]);
		rd_chk(5'h00, fw[0][31:16]);
		rd_chk(5'h01, fw[0][15:0]);
		rd_chk(5'h00, fw[1][31:16]);
		rd_chk(5'h01, fw[1][15:0]);
		wrap_up;
	end
endmodule // testbench
